// ===== src/twm_timer.sv
// 16-bit waveform timer with three compare outputs behind an apb slave
//
// How it works
// - action fields for a, b, c sit at bits 7:6, 5:4, 3:2 of control a.
// - any nonzero action field except a disconnected pwm toggle hands the pin to the channel output.
// - pin driver is enabled only by the port direction bit.
// - non-pwm modes: off, toggle, clear or set on compare match.
// - fast pwm: 10 clears on match, sets at bottom; 11 the reverse.
// - fast pwm toggle works only on channel a in mode 15.
// - fast pwm 10 or 11 with compare at top ignores match, acts at bottom.
// - dual slope: 10 clears on up match, sets on down; 11 opposite.
// - dual slope toggle works only on channel a in modes 9 and 11.
// - mode is control a bits 1:0 plus two upper bits in control b.
// - mode 0 counts to 0xFFFF, immediate compare, overflow at max.
// - modes 1-3 phase correct, fixed top, reload at top, flag at bottom.
// - modes 4 and 12 clear on match, top from compare a or capture.
// - modes 5-7 fast pwm fixed top, reload at bottom, flag at top.
// - modes 14 and 15 fast pwm, top from capture or compare a.
// - modes 8 and 9 phase and frequency correct, reload and flag at bottom.
// - modes 10 and 11 phase correct, reload at top, flag at bottom.
// - dual slope counts from zero up to top and back down.
// - dual slope with 10, compare at bottom holds low, at top holds high; 11 opposite.
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ns
module twm_timer
(
  input wire logic clk,
  input wire logic rst,
  input wire logic timer_tick,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic compare_output_a,
  output logic compare_output_b,
  output logic compare_output_c,
  output logic compare_output_a_oe,
  output logic compare_output_b_oe,
  output logic compare_output_c_oe,
  output logic overflow_flag
);
  import twm_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [1:0] wgm_hi;
    logic [15:0] counter_value;
    logic count_down;
    logic block_match;
    logic [2:0][15:0] cmp_buf;
    logic [2:0][15:0] cmp_act;
    logic [15:0] capture_value;
    logic ovf;
    logic [2:0] port_dir;
    logic [2:0] port_data;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [2:0] pin;
    logic [2:0] pin_oe;
  } twm_state_s;

  twm_state_s s;
  twm_state_s next_s;

  logic [3:0] waveform_mode_select;
  twm_kind_e kind;
  twm_update_e update_at;
  twm_ovf_e ovf_at;
  logic [15:0] top;
  logic toggle_a_ok;
  logic [2:0][1:0] action;
  logic [2:0] level;
  logic [2:0] connected;
  logic [2:0] match;
  logic [2:0] cmp_is_top;
  logic [2:0] cmp_is_bottom;
  logic dual;
  logic at_top;
  logic at_bottom;
  logic bottom_evt;
  logic top_evt;
  logic acc_start;
  logic wr_now;
  logic ovf_set;

  assign waveform_mode_select = {s.wgm_hi, s.ctrl_a[POS_WGM_LO +: 2]};
  assign action[0] = s.ctrl_a[POS_ACT_A +: 2];
  assign action[1] = s.ctrl_a[POS_ACT_B +: 2];
  assign action[2] = s.ctrl_a[POS_ACT_C +: 2];

  // ==========================================================
  // mode decode and channels
  twm_mode_decode i_twm_mode_decode
  (
    .waveform_mode_select(waveform_mode_select),
    .compare_value_a(s.cmp_act[0]),
    .capture_value(s.capture_value),
    .kind(kind),
    .update_at(update_at),
    .ovf_at(ovf_at),
    .top(top),
    .toggle_a_ok(toggle_a_ok)
  );

  assign dual = (kind == KIND_PC) || (kind == KIND_PFC);
  assign at_top = (s.counter_value == top);
  assign at_bottom = (s.counter_value == CNT_BOTTOM);
  // fast pwm reaches bottom by wrapping from top
  assign bottom_evt = timer_tick && ((kind == KIND_FAST) ? at_top : at_bottom);
  assign top_evt = timer_tick && at_top;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_chan
      assign match[gi] = (s.counter_value == s.cmp_act[gi]) && !s.block_match;
      assign cmp_is_top[gi] = (s.cmp_act[gi] == top);
      assign cmp_is_bottom[gi] = (s.cmp_act[gi] == CNT_BOTTOM);
      twm_channel i_twm_channel
      (
        .clk(clk),
        .rst(rst),
        .action(action[gi]),
        .kind(kind),
        .is_chan_a(gi == 0),
        .toggle_a_ok(toggle_a_ok),
        .tick(timer_tick),
        .match(match[gi]),
        .bottom_evt(bottom_evt),
        .counting_up(!s.count_down),
        .cmp_is_top(cmp_is_top[gi]),
        .cmp_is_bottom(cmp_is_bottom[gi]),
        .level(level[gi]),
        .connected(connected[gi])
      );
    end
  endgenerate

  // ==========================================================
  // next state
  always_comb
  begin
    next_s = s;
    acc_start = psel && penable && !s.pready;
    wr_now = psel && penable && pwrite && s.pready;
    next_s.pready = acc_start;
    if (!acc_start)
    begin
      next_s.pslverr = 1'b0;
    end

    // counting sequence
    if (timer_tick)
    begin
      next_s.block_match = 1'b0;
      case (kind)
        KIND_NORMAL:
        begin
          next_s.counter_value = s.counter_value + 16'h0001;
        end
        KIND_CTC, KIND_FAST:
        begin
          next_s.counter_value = at_top ? CNT_BOTTOM : s.counter_value + 16'h0001;
        end
        KIND_PC, KIND_PFC:
        begin
          if (!s.count_down)
          begin
            if (at_top)
            begin
              next_s.count_down = 1'b1;
              next_s.counter_value = s.counter_value - 16'h0001;
            end
            else
            begin
              next_s.counter_value = s.counter_value + 16'h0001;
            end
          end
          else if (at_bottom)
          begin
            next_s.count_down = 1'b0;
            next_s.counter_value = s.counter_value + 16'h0001;
          end
          else
          begin
            next_s.counter_value = s.counter_value - 16'h0001;
          end
        end
        default:
        begin
          next_s.counter_value = s.counter_value + 16'h0001;
        end
      endcase
    end
    if (!dual)
    begin
      next_s.count_down = 1'b0;
    end

    // overflow flag; the set is kept apart so a same-cycle clear cannot undo it
    case (ovf_at)
      OVF_AT_MAX: ovf_set = timer_tick && (s.counter_value == CNT_MAX);
      OVF_AT_TOP: ovf_set = top_evt;
      default: ovf_set = timer_tick && at_bottom;
    endcase
    if (ovf_set)
    begin
      next_s.ovf = 1'b1;
    end

    // double buffered compare reload
    if ((update_at == UPD_TOP && top_evt) || (update_at == UPD_BOTTOM && bottom_evt))
    begin
      next_s.cmp_act = s.cmp_buf;
    end

    // register read, answered one cycle into the access phase
    if (acc_start)
    begin
      next_s.prdata = 32'h0000_0000;
      case (paddr)
        OFS_CTRL_A: next_s.prdata[7:0] = s.ctrl_a;
        OFS_CTRL_B: next_s.prdata[POS_WGM_HI +: 2] = s.wgm_hi;
        OFS_COUNTER: next_s.prdata[15:0] = s.counter_value;
        OFS_CMP_A: next_s.prdata[15:0] = s.cmp_buf[0];
        OFS_CMP_B: next_s.prdata[15:0] = s.cmp_buf[1];
        OFS_CMP_C: next_s.prdata[15:0] = s.cmp_buf[2];
        OFS_CAPTURE: next_s.prdata[15:0] = s.capture_value;
        OFS_STATUS: next_s.prdata[POS_OVF] = s.ovf;
        OFS_PORT:
        begin
          next_s.prdata[POS_PORT_DIR +: 3] = s.port_dir;
          next_s.prdata[POS_PORT_DATA +: 3] = s.port_data;
        end
        default: next_s.pslverr = 1'b1;
      endcase
    end

    // register write at the completing edge
    if (wr_now)
    begin
      case (paddr)
        OFS_CTRL_A: next_s.ctrl_a = pwdata[7:0];
        OFS_CTRL_B: next_s.wgm_hi = pwdata[POS_WGM_HI +: 2];
        OFS_COUNTER:
        begin
          // a counter write masks the next tick's compare match
          next_s.counter_value = pwdata[15:0];
          next_s.block_match = 1'b1;
        end
        OFS_CMP_A, OFS_CMP_B, OFS_CMP_C:
        begin
          for (int i = 0; i < 3; i++)
          begin
            if (paddr == OFS_CMP_A + 8'(4 * i))
            begin
              next_s.cmp_buf[i] = pwdata[15:0];
              if (update_at == UPD_IMMEDIATE)
              begin
                next_s.cmp_act[i] = pwdata[15:0];
              end
            end
          end
        end
        OFS_CAPTURE: next_s.capture_value = pwdata[15:0];
        OFS_STATUS:
        begin
          // write one clears; a same-cycle hardware set still wins
          if (pwdata[POS_OVF] && !ovf_set)
          begin
            next_s.ovf = 1'b0;
          end
        end
        OFS_PORT:
        begin
          next_s.port_dir = pwdata[POS_PORT_DIR +: 3];
          next_s.port_data = pwdata[POS_PORT_DATA +: 3];
        end
        default:
        begin
          next_s.ovf = next_s.ovf;
        end
      endcase
    end

    // pin mux
    for (int i = 0; i < 3; i++)
    begin
      next_s.pin[i] = connected[i] ? level[i] : s.port_data[i];
      next_s.pin_oe[i] = s.port_dir[i];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
      s.ctrl_a <= RST_CTRL_A;
      s.wgm_hi <= RST_WGM_HI;
      s.port_dir <= RST_PORT;
      s.capture_value <= RST_WORD;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign compare_output_a = s.pin[0];
  assign compare_output_b = s.pin[1];
  assign compare_output_c = s.pin[2];
  assign compare_output_a_oe = s.pin_oe[0];
  assign compare_output_b_oe = s.pin_oe[1];
  assign compare_output_c_oe = s.pin_oe[2];
  assign overflow_flag = s.ovf;

endmodule

// ===== src/twm_pkg.sv
// shared constants and types of the waveform mode timer
package twm_pkg;

  // ==========================================================
  // register offsets (byte addresses on the apb bus)
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_COUNTER = 8'h08;
  localparam logic [7:0] OFS_CMP_A = 8'h0C;
  localparam logic [7:0] OFS_CMP_B = 8'h10;
  localparam logic [7:0] OFS_CMP_C = 8'h14;
  localparam logic [7:0] OFS_CAPTURE = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_PORT = 8'h20;

  // ==========================================================
  // field positions
  localparam int POS_ACT_A = 6;
  localparam int POS_ACT_B = 4;
  localparam int POS_ACT_C = 2;
  localparam int POS_WGM_LO = 0;
  localparam int POS_WGM_HI = 3;
  localparam int POS_OVF = 0;
  localparam int POS_PORT_DIR = 0;
  localparam int POS_PORT_DATA = 4;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_CTRL_A = 8'h00;
  localparam logic [1:0] RST_WGM_HI = 2'h0;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [2:0] RST_PORT = 3'h0;

  // ==========================================================
  // counter limits
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;

  // ==========================================================
  // action codes and waveform modes
  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [3:0] WGM_PFC_CMPA = 4'h9;
  localparam logic [3:0] WGM_PC_CMPA = 4'hB;
  localparam logic [3:0] WGM_FAST_CMPA = 4'hF;

  typedef enum logic [2:0] {KIND_NORMAL, KIND_CTC, KIND_FAST, KIND_PC, KIND_PFC} twm_kind_e;
  typedef enum logic [1:0] {UPD_IMMEDIATE, UPD_TOP, UPD_BOTTOM} twm_update_e;
  typedef enum logic [1:0] {OVF_AT_MAX, OVF_AT_TOP, OVF_AT_BOTTOM} twm_ovf_e;

endpackage

// ===== src/twm_mode_decode.sv
// waveform mode decoder: count sequence, top source, reload and overflow points
`timescale 1ns/1ns
module twm_mode_decode
(
  input wire logic [3:0] waveform_mode_select,
  input wire logic [15:0] compare_value_a,
  input wire logic [15:0] capture_value,
  output twm_pkg::twm_kind_e kind,
  output twm_pkg::twm_update_e update_at,
  output twm_pkg::twm_ovf_e ovf_at,
  output logic [15:0] top,
  output logic toggle_a_ok
);
  import twm_pkg::*;

  always_comb
  begin
    kind = KIND_NORMAL;
    update_at = UPD_IMMEDIATE;
    ovf_at = OVF_AT_MAX;
    top = CNT_MAX;
    case (waveform_mode_select)
      4'h0:
      begin
        top = CNT_MAX;
      end
      4'h1, 4'h2, 4'h3:
      begin
        kind = KIND_PC;
        update_at = UPD_TOP;
        ovf_at = OVF_AT_BOTTOM;
        top = (waveform_mode_select == 4'h1) ? TOP_8BIT :
              (waveform_mode_select == 4'h2) ? TOP_9BIT : TOP_10BIT;
      end
      4'h4, 4'hC:
      begin
        kind = KIND_CTC;
        top = (waveform_mode_select == 4'h4) ? compare_value_a : capture_value;
      end
      4'h5, 4'h6, 4'h7:
      begin
        kind = KIND_FAST;
        update_at = UPD_BOTTOM;
        ovf_at = OVF_AT_TOP;
        top = (waveform_mode_select == 4'h5) ? TOP_8BIT :
              (waveform_mode_select == 4'h6) ? TOP_9BIT : TOP_10BIT;
      end
      4'h8, 4'h9:
      begin
        kind = KIND_PFC;
        update_at = UPD_BOTTOM;
        ovf_at = OVF_AT_BOTTOM;
        top = (waveform_mode_select == 4'h8) ? capture_value : compare_value_a;
      end
      4'hA, 4'hB:
      begin
        kind = KIND_PC;
        update_at = UPD_TOP;
        ovf_at = OVF_AT_BOTTOM;
        top = (waveform_mode_select == 4'hA) ? capture_value : compare_value_a;
      end
      4'hE, 4'hF:
      begin
        kind = KIND_FAST;
        update_at = UPD_BOTTOM;
        ovf_at = OVF_AT_TOP;
        top = (waveform_mode_select == 4'hE) ? capture_value : compare_value_a;
      end
      default:
      begin
        // reserved encoding runs as plain normal counting
        kind = KIND_NORMAL;
      end
    endcase
    toggle_a_ok = (waveform_mode_select == WGM_FAST_CMPA) ||
                  (waveform_mode_select == WGM_PFC_CMPA) ||
                  (waveform_mode_select == WGM_PC_CMPA);
  end

endmodule

// ===== src/twm_channel.sv
// one compare output channel: action decode and output level
`timescale 1ns/1ns
module twm_channel
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] action,
  input twm_pkg::twm_kind_e kind,
  input wire logic is_chan_a,
  input wire logic toggle_a_ok,
  input wire logic tick,
  input wire logic match,
  input wire logic bottom_evt,
  input wire logic counting_up,
  input wire logic cmp_is_top,
  input wire logic cmp_is_bottom,
  output logic level,
  output logic connected
);
  import twm_pkg::*;

  typedef struct packed {
    logic level;
  } twm_chan_s;

  twm_chan_s s;
  twm_chan_s next_s;
  logic pwm;
  logic dual;

  always_comb
  begin
    next_s = s;
    pwm = (kind == KIND_FAST) || (kind == KIND_PC) || (kind == KIND_PFC);
    dual = (kind == KIND_PC) || (kind == KIND_PFC);
    // toggle only survives in pwm modes for channel a in its own modes
    connected = (action != ACT_OFF) &&
                !(pwm && action == ACT_TOGGLE && !(is_chan_a && toggle_a_ok));
    if (connected && tick)
    begin
      if (action == ACT_TOGGLE)
      begin
        if (match)
        begin
          next_s.level = ~s.level;
        end
      end
      else if (!pwm)
      begin
        if (match)
        begin
          next_s.level = action[0];
        end
      end
      else if (!dual)
      begin
        if (match && !cmp_is_top)
        begin
          next_s.level = action[0];
        end
        else if (bottom_evt)
        begin
          next_s.level = ~action[0];
        end
      end
      else if (cmp_is_bottom)
      begin
        next_s.level = action[0];
      end
      else if (cmp_is_top)
      begin
        next_s.level = ~action[0];
      end
      else if (match)
      begin
        next_s.level = counting_up ? action[0] : ~action[0];
      end
    end
    level = s.level;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

endmodule

// ===== tb/twm_pin_model.sv
// board model of the three compare output pins with pull-ups
`timescale 1ns/1ns
module twm_pin_model
(
  input wire logic [2:0] drive,
  input wire logic [2:0] drive_oe,
  output logic [2:0] pin
);
  // ==========================================================
  // pin resolution
  // an undriven pin floats up to the pull-up, never keeps the last level
  assign pin = (drive & drive_oe) | ~drive_oe;
endmodule

// ===== tb/twm_timer_chk.sv
// assertion checker watching the waveform timer ports
`timescale 1ns/1ns
module twm_timer_chk
  import twm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic timer_tick,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic compare_output_a,
  input wire logic compare_output_b,
  input wire logic compare_output_c,
  input wire logic compare_output_a_oe,
  input wire logic compare_output_b_oe,
  input wire logic compare_output_c_oe,
  input wire logic overflow_flag
);
  // ==========================================================
  // properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic [2:0] pins;
  logic [2:0] oes;
  assign pins = {compare_output_c, compare_output_b, compare_output_a};
  assign oes = {compare_output_c_oe, compare_output_b_oe, compare_output_a_oe};
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  a_idle_quiet: assert property (!psel |=> !pready)
    else $error("pready while idle");
  a_err_reads_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error read not zero");
  a_oe_by_write: assert property (!$stable(oes) |->
    $past(psel && pwrite) || $past(psel && pwrite, 2)) else $error("oe moved alone");
  a_pin_cause: assert property (!$stable(pins) |-> $past(timer_tick) ||
    $past(timer_tick, 2) || $past(psel && pwrite, 2) || $past(psel && pwrite, 3))
    else $error("pin moved without cause");
  a_flag_set_tick: assert property ($rose(overflow_flag) |->
    $past(timer_tick) || $past(timer_tick, 2)) else $error("flag set without tick");
  a_flag_clear_write: assert property ($fell(overflow_flag) |->
    $past(psel && pwrite && pwdata[POS_OVF] && paddr == OFS_STATUS, 2) ||
    $past(psel && pwrite && pwdata[POS_OVF] && paddr == OFS_STATUS))
    else $error("flag cleared alone");
  c_flag: cover property ($rose(overflow_flag));
  c_err: cover property (pslverr);
  c_pin_a: cover property ($rose(compare_output_a));
endmodule

bind twm_timer twm_timer_chk i_twm_timer_chk (.clk(clk), .rst(rst), .timer_tick(timer_tick),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .compare_output_a(compare_output_a),
  .compare_output_b(compare_output_b), .compare_output_c(compare_output_c),
  .compare_output_a_oe(compare_output_a_oe), .compare_output_b_oe(compare_output_b_oe),
  .compare_output_c_oe(compare_output_c_oe), .overflow_flag(overflow_flag));

// ===== tb/tb_twm_timer.sv
// self-checking testbench for the waveform mode timer
`timescale 1ns/1ns
module tb_twm_timer;
  import twm_pkg::*;
  // ==========================================================
  // stimulus and design
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic timer_tick = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [31:0] r;
  logic pready;
  logic pslverr;
  logic er;
  logic ovf;
  logic [2:0] outs;
  logic [2:0] oes;
  logic [2:0] pin;
  logic [7:0] a;
  logic [7:0] tbl [4] = '{OFS_CTRL_A, OFS_CTRL_B, OFS_CMP_B, OFS_PORT};
  logic [7:0] zro [4] = '{OFS_CTRL_A, OFS_CTRL_B, OFS_STATUS, OFS_PORT};
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  int seed = 11;

  always #50 clk = ~clk;

  twm_timer i_twm_timer (.clk(clk), .rst(rst), .timer_tick(timer_tick), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .compare_output_a(outs[0]),
    .compare_output_b(outs[1]), .compare_output_c(outs[2]), .compare_output_a_oe(oes[0]),
    .compare_output_b_oe(oes[1]), .compare_output_c_oe(oes[2]), .overflow_flag(ovf));
  twm_pin_model i_twm_pin_model (.drive(outs), .drive_oe(oes), .pin(pin));

  // ==========================================================
  // helpers
  task automatic stop_test();
    if (err_total == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      err_total++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // holds the request until pready; three idle edges let the pins settle
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1)
      @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    repeat (3) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'h1, ad, d);
  endtask

  task automatic rdc(input logic [7:0] ad, input logic [31:0] e);
    apb(1'h0, ad, 32'h0);
    chk(rd, e);
  endtask

  task automatic run(input int n);
    timer_tick <= 1'h1;
    repeat (n) @(posedge clk);
    timer_tick <= 1'h0;
    repeat (3) @(posedge clk);
  endtask

  task automatic do_reset();
    rst <= 1'h1;
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
  endtask

  function automatic logic [31:0] reg_mask(input logic [7:0] ad);
    case (ad)
      OFS_CTRL_A: return 32'hFF;
      OFS_CTRL_B: return 32'h18;
      OFS_PORT: return 32'h77;
      default: return 32'hFFFF;
    endcase
  endfunction

  function automatic logic [2:0] pin_exp(input logic [2:0] lvl, input logic [2:0] dir);
    return (lvl & dir) | ~dir;
  endfunction

  // ==========================================================
  // scenarios
  initial
  begin
    do_reset();
    chk({oes, outs, ovf}, 32'h0);
    foreach (zro[k])
      rdc(zro[k], 32'h0);
    apb(1'h0, 8'h24, 32'h0);
    chk(er, 1'h1);
    chk(rd, 32'h0);
    for (int k = 0; k < 12; k++)
    begin
      r = $random(seed);
      a = tbl[r[31:30]];
      // the upper mode bits never both set, so the reserved mode stays out
      if (a == OFS_CTRL_B)
        r[POS_WGM_HI] = 1'h0;
      wr(a, r);
      rdc(a, r & reg_mask(a));
    end
    // port path, direction gate and takeover
    do_reset();
    wr(OFS_PORT, 32'h50);
    chk({oes, outs, pin}, {3'h0, 3'h5, pin_exp(3'h5, 3'h0)});
    wr(OFS_PORT, 32'h57);
    chk({oes, pin}, {3'h7, pin_exp(3'h5, 3'h7)});
    wr(OFS_CTRL_A, 32'hFC);
    chk(outs, 3'h0);
    // normal counting: set, clear, toggle, overflow at max
    do_reset();
    wr(OFS_PORT, 32'h27);
    wr(OFS_CMP_A, 32'h3);
    wr(OFS_CMP_B, 32'h3);
    wr(OFS_CMP_C, 32'h3);
    wr(OFS_CTRL_A, 32'hE4);
    wr(OFS_COUNTER, 32'h0);
    run(6);
    chk(pin, 3'h5);
    wr(OFS_COUNTER, 32'hFFFE);
    run(3);
    chk(ovf, 1'h1);
    wr(OFS_STATUS, 32'h1);
    chk(ovf, 1'h0);
    // fast pwm 8 bit: bottom then match, toggle disconnected
    do_reset();
    wr(OFS_PORT, 32'h47);
    wr(OFS_CMP_A, 32'h10);
    wr(OFS_CMP_B, 32'h10);
    wr(OFS_CTRL_B, 32'h8);
    wr(OFS_CTRL_A, 32'hB5);
    wr(OFS_COUNTER, 32'hF0);
    run(24);
    chk({ovf, pin}, 4'hD);
    run(16);
    chk(pin, 3'h6);
    // phase correct 8 bit: up match, down match, flag at bottom
    do_reset();
    wr(OFS_PORT, 32'h07);
    wr(OFS_CMP_A, 32'h80);
    wr(OFS_CMP_B, 32'h80);
    wr(OFS_CTRL_A, 32'hB1);
    wr(OFS_COUNTER, 32'h70);
    run(32);
    chk({ovf, pin}, 4'h2);
    run(240);
    chk({ovf, pin}, 4'h1);
    run(144);
    chk({ovf, pin}, 4'h9);
    // fast pwm with compare a as top: toggle on channel a only
    do_reset();
    wr(OFS_PORT, 32'h27);
    wr(OFS_CMP_A, 32'hF);
    wr(OFS_CTRL_B, 32'h18);
    wr(OFS_CTRL_A, 32'h53);
    wr(OFS_COUNTER, 32'h0);
    run(24);
    chk({ovf, pin}, 4'hB);
    // phase and frequency correct, compare a as top: a toggles, b and c pinned
    do_reset();
    wr(OFS_PORT, 32'h07);
    wr(OFS_CMP_A, 32'h8);
    wr(OFS_CMP_C, 32'h8);
    wr(OFS_CTRL_B, 32'h10);
    wr(OFS_CTRL_A, 32'h79);
    wr(OFS_COUNTER, 32'h0);
    run(12);
    chk({ovf, pin}, 4'hF);
    run(16);
    chk({ovf, pin}, 4'hE);
    stop_test();
  end
endmodule
